// ==== hdl/pwr_idle_defs.vh ====
/*
 Constants for the power mode and flash read timing block: register addresses,
 field positions, reset values and timing counts.
 Assumes inclusion by bare name from the design files under hdl/.
*/
`ifndef PWR_IDLE_DEFS_VH
`define PWR_IDLE_DEFS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_FLASH_READ_SCALE 8'hb6
`define ADDR_DUMMY_WRITE_SINK 8'he5
`define ADDR_POWER_CONTROL 8'h87
`define ADDR_PMU_CONFIG 8'hb5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_BYPASS 6
`define BIT_IDLE_SEL 0
`define BIT_STOP_SEL 1
`define BIT_SUSPEND_SEL 6
`define BIT_SLEEP_SEL 7
`define MASK_FLASH_READ_SCALE 8'h40

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_FLASH_READ_SCALE 8'h00
`define RST_DUMMY_WRITE_SINK 8'h00
`define RST_POWER_CONTROL 8'h00
`define RST_PMU_CONFIG 8'h00
`define RESET_VECTOR 16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_PS 4000
`define ONESHOT_NS 40
`define ONESHOT_CYCLES ((`ONESHOT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SYSCLK_READ_CYCLES 1
`define WAKE_FLAG_HOLD_CYCLES 2'h2

`endif

// ==== hdl/flash_read_timer.v ====
/*
 Flash read strobe timer: the one-shot path or the system clock path times
 each read. Assumes read requests come from the same clock domain.
*/
`include "pwr_idle_defs.vh"

module flash_read_timer #(
  parameter ONESHOT_CYC = `ONESHOT_CYCLES,
  parameter SYSCLK_CYC = `SYSCLK_READ_CYCLES
) (
  input wire clk,
  input wire rstn,
  input wire bypass,
  input wire read_req,
  output wire read_busy,
  output reg read_done
);

  reg [7:0] count;
  wire [7:0] load_val;

  // ----------------------------------------
  // Read timing
  // ----------------------------------------
  // Bypass clear means the one-shot sets the read time; set means sysclk does
  assign load_val = bypass ? SYSCLK_CYC[7:0] : ONESHOT_CYC[7:0]; // RULE1 RULE2
  assign read_busy = (count != 8'h00);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 8'h00;
      read_done <= 1'b0;
    end else begin
      read_done <= (count == 8'h01);
      if (read_req && !read_busy) begin
        count <= load_val;
      end else if (read_busy) begin
        count <= count - 8'h01;
      end
    end
  end

endmodule // flash_read_timer

// ==== hdl/power_mode_ctrl.v ====
/*
 Power mode controller: idle entry and exit, stop, suspend and sleep summary
 behaviour, and the flash scale and dummy sink registers on the SFR port.
 Assumes one system clock, SFR strobes synchronous to it, and wake and
 interrupt pins that come from other clock or pin domains.
*/
`include "pwr_idle_defs.vh"

// Behaviour
// RULE1: Bypass clear: one-shot times flash reads
// RULE2: Bypass set: system clock times reads
// RULE3: Third opcode after bypass clear indeterminate
// RULE4: Flash scale reserved bits read zero
// RULE5: Dummy sink accepts writes, no effect
// RULE6: Five modes: normal, idle, stop, suspend, sleep
// RULE7: Idle select halts CPU after instruction
// RULE8: Idle keeps registers and memory unchanged
// RULE9: Enabled interrupt clears idle, resumes CPU
// RULE10: Service interrupt, resume after idle instruction
// RULE11: Reset ends idle, fetch at zero
// RULE12: Enabled watchdog runs, resets out of idle
// RULE13: Software may disable watchdog before idle
// RULE14: Software clears bypass before idle
// RULE15: Stop halts code, oscillator; reset exits
// RULE16: Suspend gates clock, fast wake, resume
// RULE17: Sleep/suspend wake on clock, match, comparator, pin; code: comparator wakes sleep only if two-cell
module power_mode_ctrl #(
  parameter ONESHOT_CYC = `ONESHOT_CYCLES,
  parameter SYSCLK_CYC = `SYSCLK_READ_CYCLES
) (
  // Clock and reset
  input wire CLK_SYS,
  input wire RSTN,
  // SFR port
  input wire SFR_WR,
  input wire SFR_RD,
  input wire [7:0] SFR_ADDR,
  input wire [7:0] SFR_WDATA,
  output reg [7:0] SFR_RDATA,
  output wire SFR_HIT,
  // CPU handshake
  input wire INSTR_DONE,
  input wire INT_PENDING,
  input wire WDT_RESET,
  input wire WDT_ENABLED,
  output wire CPU_HALT,
  output wire INT_SERVICE,
  output reg [15:0] RESUME_PC_SEL,
  output wire RESUME_NEXT,
  // Flash read path
  input wire FLASH_READ_REQ,
  output wire FLASH_READ_BUSY,
  output wire FLASH_READ_DONE,
  output wire OPCODE3_INVALID,
  // Wake sources
  input wire WAKE_RTC,
  input wire WAKE_PORT_MATCH,
  input wire WAKE_CMP0,
  input wire WAKE_RST_PIN,
  input wire TWO_CELL,
  // Clock and power controls
  output wire PRECISION_OSC_EN,
  output wire INTERNAL_OSC_EN,
  output wire SYSCLK_GATE,
  output wire CORE_SUPPLY_EN,
  output wire [4:0] MODE
);

  // ----------------------------------------
  // Mode states, one-hot
  // ----------------------------------------
  localparam [4:0] ST_NORMAL = 5'h01;
  localparam [4:0] ST_IDLE = 5'h02;
  localparam [4:0] ST_STOP = 5'h04;
  localparam [4:0] ST_SUSPEND = 5'h08;
  localparam [4:0] ST_SLEEP = 5'h10;

  reg [4:0] state;
  reg [4:0] next_state;
  reg [7:0] flash_read_scale;
  reg [7:0] dummy_write_sink;
  reg [7:0] power_control_reg;
  reg [7:0] pmu_config;
  reg idle_arm;
  reg stop_arm;
  reg bypass_prev;
  reg [1:0] fetch_count;
  reg fetch_track;
  reg [1:0] wake_hold;
  reg int_service;
  reg resume_next;
  reg [3:0] wake_s1;
  reg [3:0] wake_s2;
  reg [2:0] async_s1;
  reg [2:0] async_s2;
  wire int_sync;
  wire wdt_sync;
  wire two_cell_sync;
  wire wake_any;
  wire wr_scale;
  wire wr_sink;
  wire wr_power_control_reg;
  wire wr_pmu;
  wire bypass;
  wire in_normal;
  wire in_idle;
  wire in_stop;
  wire in_suspend;
  wire in_sleep;

  // ----------------------------------------
  // Mode decodes
  // ----------------------------------------
  // Named decodes keep the outputs other than MODE right if state codes are renumbered; MODE is the raw state
  assign in_normal = (state == ST_NORMAL);
  assign in_idle = (state == ST_IDLE);
  assign in_stop = (state == ST_STOP);
  assign in_suspend = (state == ST_SUSPEND);
  assign in_sleep = (state == ST_SLEEP);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Second stage only is read; first stage feeds nothing else
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      wake_s1 <= 4'h0;
      wake_s2 <= 4'h0;
      async_s1 <= 3'h0;
      async_s2 <= 3'h0;
    end else begin
      wake_s1 <= {WAKE_RST_PIN, WAKE_CMP0, WAKE_PORT_MATCH, WAKE_RTC};
      wake_s2 <= wake_s1;
      async_s1 <= {TWO_CELL, WDT_RESET, INT_PENDING};
      async_s2 <= async_s1;
    end
  end

  assign int_sync = async_s2[0];
  assign wdt_sync = async_s2[1];
  assign two_cell_sync = async_s2[2];
  // Comparator wake only counts in sleep when supply is two-cell
  assign wake_any = wake_s2[0] | wake_s2[1] | wake_s2[3] |
    (wake_s2[2] & (in_suspend | two_cell_sync)); // RULE17

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  assign wr_scale = SFR_WR && (SFR_ADDR == `ADDR_FLASH_READ_SCALE);
  assign wr_sink = SFR_WR && (SFR_ADDR == `ADDR_DUMMY_WRITE_SINK);
  assign wr_power_control_reg = SFR_WR && (SFR_ADDR == `ADDR_POWER_CONTROL);
  assign wr_pmu = SFR_WR && (SFR_ADDR == `ADDR_PMU_CONFIG);
  assign bypass = flash_read_scale[`BIT_BYPASS];

  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      flash_read_scale <= `RST_FLASH_READ_SCALE;
      dummy_write_sink <= `RST_DUMMY_WRITE_SINK;
      power_control_reg <= `RST_POWER_CONTROL;
      pmu_config <= `RST_PMU_CONFIG;
      idle_arm <= 1'b0;
      stop_arm <= 1'b0;
    end else begin
      // Reserved bits masked: they never store a one
      if (wr_scale) begin
        flash_read_scale <= SFR_WDATA & `MASK_FLASH_READ_SCALE; // RULE4
      end
      // Stored but never read back or used anywhere
      if (wr_sink) begin
        dummy_write_sink <= SFR_WDATA; // RULE5
      end
      if (wr_power_control_reg) begin
        power_control_reg <= SFR_WDATA;
        idle_arm <= SFR_WDATA[`BIT_IDLE_SEL];
        stop_arm <= SFR_WDATA[`BIT_STOP_SEL];
      end else if (state == ST_IDLE && int_sync) begin
        // Interrupt wake clears the select bit; a same-cycle write wins above
        power_control_reg[`BIT_IDLE_SEL] <= 1'b0; // RULE9
      end else if (INSTR_DONE) begin
        idle_arm <= 1'b0;
        stop_arm <= 1'b0;
      end
      if (wr_pmu) begin
        pmu_config <= SFR_WDATA;
      end else if (state != ST_NORMAL && next_state == ST_NORMAL) begin
        pmu_config[`BIT_SUSPEND_SEL] <= 1'b0;
        pmu_config[`BIT_SLEEP_SEL] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  // Decode only; the port inserts no wait states
  assign SFR_HIT = (SFR_ADDR == `ADDR_FLASH_READ_SCALE) ||
    (SFR_ADDR == `ADDR_DUMMY_WRITE_SINK) || (SFR_ADDR == `ADDR_POWER_CONTROL) ||
    (SFR_ADDR == `ADDR_PMU_CONFIG);

  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      SFR_RDATA <= 8'h00;
    end else if (SFR_RD) begin
      case (SFR_ADDR)
        `ADDR_FLASH_READ_SCALE: SFR_RDATA <= flash_read_scale & `MASK_FLASH_READ_SCALE; // RULE4
        `ADDR_POWER_CONTROL: SFR_RDATA <= power_control_reg;
        // Wake flags read zero for two clocks after a wake
        `ADDR_PMU_CONFIG: SFR_RDATA <= (wake_hold != 2'b00) ? 8'h00 : pmu_config;
        // Write-only sink and unmapped addresses read zero
        default: SFR_RDATA <= 8'h00; // RULE5
      endcase
    end
  end

  // ----------------------------------------
  // Mode sequencer
  // ----------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_NORMAL: begin
        // Entry waits for the setting instruction to retire
        if (INSTR_DONE && idle_arm) begin
          next_state = ST_IDLE; // RULE7
        end else if (INSTR_DONE && stop_arm) begin
          next_state = ST_STOP; // RULE15
        end else if (INSTR_DONE && pmu_config[`BIT_SLEEP_SEL]) begin
          next_state = ST_SLEEP;
        end else if (INSTR_DONE && pmu_config[`BIT_SUSPEND_SEL]) begin
          next_state = ST_SUSPEND; // RULE16
        end
      end
      ST_IDLE: begin
        // Watchdog stays alive in idle and its reset ends the mode
        if (wdt_sync && WDT_ENABLED) begin
          next_state = ST_NORMAL; // RULE12 RULE13
        end else if (int_sync) begin
          next_state = ST_NORMAL; // RULE9
        end
      end
      ST_STOP: begin
        // Only a reset leaves stop; the watchdog reset counts as one
        if (wdt_sync && WDT_ENABLED) begin
          next_state = ST_NORMAL; // RULE15
        end
      end
      ST_SUSPEND, ST_SLEEP: begin
        if (wake_any) begin
          next_state = ST_NORMAL; // RULE16 RULE17
        end
      end
      default: next_state = ST_NORMAL;
    endcase
  end

  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state <= ST_NORMAL;
      int_service <= 1'b0;
      resume_next <= 1'b0;
      RESUME_PC_SEL <= `RESET_VECTOR;
      wake_hold <= 2'b00;
    end else begin
      state <= next_state;
      int_service <= 1'b0;
      resume_next <= 1'b0;
      if (state == ST_IDLE && next_state == ST_NORMAL) begin
        if (wdt_sync && WDT_ENABLED) begin
          // Watchdog path: restart at the reset vector
          RESUME_PC_SEL <= `RESET_VECTOR; // RULE11 RULE12
        end else begin
          // Service first, then continue after the idle-setting instruction
          int_service <= 1'b1; // RULE10
          resume_next <= 1'b1; // RULE10
        end
      end
      if (state == ST_STOP && next_state == ST_NORMAL) begin
        RESUME_PC_SEL <= `RESET_VECTOR; // RULE11
      end
      if ((state == ST_SUSPEND || state == ST_SLEEP) && next_state == ST_NORMAL) begin
        resume_next <= 1'b1; // RULE16
        // Flags read zero until the wake source has settled
        wake_hold <= `WAKE_FLAG_HOLD_CYCLES;
      end else if (wake_hold != 2'b00) begin
        wake_hold <= wake_hold - 2'b01;
      end
    end
  end

  // ----------------------------------------
  // Mode outputs
  // ----------------------------------------
  // Halt freezes the core; registers and memory keep their contents
  assign CPU_HALT = !in_normal; // RULE7 RULE8
  assign INT_SERVICE = int_service;
  assign RESUME_NEXT = resume_next;
  assign PRECISION_OSC_EN = !(in_stop | in_suspend | in_sleep); // RULE15
  assign INTERNAL_OSC_EN = !(in_suspend | in_sleep); // RULE16
  assign SYSCLK_GATE = in_suspend | in_sleep; // RULE16
  assign CORE_SUPPLY_EN = !in_sleep;
  assign MODE = state; // RULE6

  // ----------------------------------------
  // Bypass falling edge and fetch tracking
  // ----------------------------------------
  // Flags the third opcode fetch after bypass clear; software must pad it
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      bypass_prev <= 1'b0;
      fetch_track <= 1'b0;
      fetch_count <= 2'b00;
    end else begin
      bypass_prev <= bypass;
      if (bypass_prev && !bypass) begin
        fetch_track <= 1'b1; // RULE3
        fetch_count <= 2'b00;
      end else if (fetch_track && FLASH_READ_DONE) begin
        // Count completed reads so the flag covers the whole third fetch
        fetch_count <= fetch_count + 2'b01;
        if (fetch_count == 2'b10) begin
          fetch_track <= 1'b0;
        end
      end
    end
  end

  assign OPCODE3_INVALID = fetch_track && (fetch_count == 2'b10); // RULE3

  // ----------------------------------------
  // Flash read timer
  // ----------------------------------------
  // Fetches are refused while the system clock is gated
  flash_read_timer #(
    .ONESHOT_CYC(ONESHOT_CYC),
    .SYSCLK_CYC(SYSCLK_CYC)
  ) u_timer (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .bypass(bypass), // RULE1 RULE2 RULE14
    .read_req(FLASH_READ_REQ && !SYSCLK_GATE),
    .read_busy(FLASH_READ_BUSY),
    .read_done(FLASH_READ_DONE)
  );

endmodule // power_mode_ctrl

// ==== sim/pwr_idle_properties.sv ====
/*
 Port assertions for the power mode and flash read timing block.
 Assumes binding to power_mode_ctrl and the header on the include path.
*/
`include "pwr_idle_defs.vh"

module pwr_idle_properties #(
  parameter int ONESHOT_CYC = 10
) (
  // Clock and reset
  input wire logic CLK_SYS, RSTN,
  // Register port
  input wire logic SFR_WR, SFR_RD,
  input wire logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA,
  // CPU handshake
  input wire logic INSTR_DONE, INT_PENDING, WDT_RESET, WDT_ENABLED,
  input wire logic CPU_HALT, INT_SERVICE, RESUME_NEXT,
  input wire logic [15:0] RESUME_PC_SEL,
  // Flash, clocks and mode
  input wire logic FLASH_READ_REQ, FLASH_READ_BUSY, FLASH_READ_DONE, OPCODE3_INVALID,
  input wire logic PRECISION_OSC_EN, INTERNAL_OSC_EN, SYSCLK_GATE,
  input wire logic [4:0] MODE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  localparam int OS_DONE = ONESHOT_CYC + 1;
  logic byp;

  // ----------------------------------------
  // Bypass shadow
  // ----------------------------------------
  // Seen only through writes; a watchdog exit is not followed by reads
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) byp <= 1'b0;
    else if (SFR_WR && SFR_ADDR == `ADDR_FLASH_READ_SCALE) byp <= SFR_WDATA[6];
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence rd_take(b);
    FLASH_READ_REQ && !FLASH_READ_BUSY && MODE == 5'h01 && byp == b;
  endsequence
  sequence idle_int;
    MODE == 5'h02 && INT_PENDING;
  endsequence

  a_clock_read: assert property (
    rd_take(1'b1) |-> ##1 !FLASH_READ_DONE ##1 FLASH_READ_DONE) else $error("fast read late");
  a_oneshot_read: assert property (
    rd_take(1'b0) |-> ##OS_DONE FLASH_READ_DONE) else $error("one-shot read timing");
  a_third_fetch: assert property (
    $rose(OPCODE3_INVALID) |-> !byp && $past(FLASH_READ_DONE))
    else $error("third fetch flag out of place");
  a_scale_mask: assert property (
    SFR_RD && SFR_ADDR == `ADDR_FLASH_READ_SCALE |=> SFR_RDATA == {1'b0, byp, 6'h00})
    else $error("scale read value");
  a_sink_zero: assert property (
    SFR_RD && SFR_ADDR == `ADDR_DUMMY_WRITE_SINK |=> SFR_RDATA == 8'h00)
    else $error("sink read not zero");
  a_one_mode: assert property ($onehot(MODE) && CPU_HALT == (MODE != 5'h01))
    else $error("mode encoding");
  a_idle_entry: assert property (
    $rose(MODE[1]) |-> $past(INSTR_DONE) || $past(INSTR_DONE, 2)) else $error("early idle");
  a_idle_keep: assert property (MODE == 5'h02 && !SFR_RD |=> $stable(SFR_RDATA))
    else $error("data moved in idle");
  a_int_wake: assert property (
    idle_int |-> ##[1:4] (INT_SERVICE && RESUME_NEXT)) else $error("interrupt wake missing");
  a_wdt_exit: assert property (
    MODE == 5'h02 && WDT_RESET && WDT_ENABLED |-> ##[1:4]
    (MODE == 5'h01 && RESUME_PC_SEL == `RESET_VECTOR)) else $error("watchdog exit");
  a_stop_osc: assert property (MODE[2] |-> !PRECISION_OSC_EN && CPU_HALT)
    else $error("stop oscillator on");
  a_suspend_clk: assert property (MODE[3] |-> SYSCLK_GATE && !INTERNAL_OSC_EN)
    else $error("suspend clock running");
endmodule // pwr_idle_properties

bind power_mode_ctrl pwr_idle_properties #(.ONESHOT_CYC(ONESHOT_CYC)) props (
  .CLK_SYS(CLK_SYS), .RSTN(RSTN), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
  .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
  .INSTR_DONE(INSTR_DONE), .INT_PENDING(INT_PENDING), .WDT_RESET(WDT_RESET),
  .WDT_ENABLED(WDT_ENABLED), .CPU_HALT(CPU_HALT), .INT_SERVICE(INT_SERVICE),
  .RESUME_NEXT(RESUME_NEXT), .RESUME_PC_SEL(RESUME_PC_SEL),
  .FLASH_READ_REQ(FLASH_READ_REQ), .FLASH_READ_BUSY(FLASH_READ_BUSY),
  .FLASH_READ_DONE(FLASH_READ_DONE), .OPCODE3_INVALID(OPCODE3_INVALID),
  .PRECISION_OSC_EN(PRECISION_OSC_EN), .INTERNAL_OSC_EN(INTERNAL_OSC_EN),
  .SYSCLK_GATE(SYSCLK_GATE), .MODE(MODE));

// ==== sim/testbench.sv ====
/*
 Self-checking bench for power_mode_ctrl.
 Assumes the design and its header from hdl/; inputs move on falling edges.
*/
`include "pwr_idle_defs.vh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OS = 5;
  logic CLK_SYS = 0, RSTN = 0, SFR_WR = 0, SFR_RD = 0, INSTR_DONE = 0, INT_PENDING = 0;
  logic WDT_RESET = 0, WDT_ENABLED = 0, FLASH_READ_REQ = 0, TWO_CELL = 1, rd_pend = 0;
  logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA, sc, exp_r;
  logic [3:0] wake = 4'h0;
  logic [15:0] RESUME_PC_SEL;
  logic [4:0] MODE;
  logic SFR_HIT, CPU_HALT, INT_SERVICE, RESUME_NEXT, FLASH_READ_BUSY, FLASH_READ_DONE;
  logic OPCODE3_INVALID, PRECISION_OSC_EN, INTERNAL_OSC_EN, SYSCLK_GATE, CORE_SUPPLY_EN;
  int fails = 0, check_count = 0, cycles = 0, seed = 35493, n;
  logic [7:0] exp_q[$];

  power_mode_ctrl #(.ONESHOT_CYC(OS)) dut (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
    .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT),
    .INSTR_DONE(INSTR_DONE), .INT_PENDING(INT_PENDING), .WDT_RESET(WDT_RESET),
    .WDT_ENABLED(WDT_ENABLED), .CPU_HALT(CPU_HALT), .INT_SERVICE(INT_SERVICE),
    .RESUME_PC_SEL(RESUME_PC_SEL), .RESUME_NEXT(RESUME_NEXT),
    .FLASH_READ_REQ(FLASH_READ_REQ), .FLASH_READ_BUSY(FLASH_READ_BUSY),
    .FLASH_READ_DONE(FLASH_READ_DONE), .OPCODE3_INVALID(OPCODE3_INVALID),
    .WAKE_RTC(wake[0]), .WAKE_PORT_MATCH(wake[1]), .WAKE_CMP0(wake[2]),
    .WAKE_RST_PIN(wake[3]), .TWO_CELL(TWO_CELL), .PRECISION_OSC_EN(PRECISION_OSC_EN),
    .INTERNAL_OSC_EN(INTERNAL_OSC_EN), .SYSCLK_GATE(SYSCLK_GATE),
    .CORE_SUPPLY_EN(CORE_SUPPLY_EN), .MODE(MODE));

  // ----------------------------------------
  // Clock, watchdog on the run, read monitor
  // ----------------------------------------
  initial begin
    forever #2 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) begin
    rd_pend <= SFR_RD;
    cycles++;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  // Read data is registered, so the note is taken off one edge later
  always @(negedge CLK_SYS) begin
    if (rd_pend) begin
      exp_r = exp_q.pop_front();
      `CHK("read data", exp_r, SFR_RDATA)
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task sfr_write(input logic [7:0] a, input logic [7:0] d);
    SFR_ADDR = a;
    SFR_WDATA = d;
    SFR_WR = 1;
    @(negedge CLK_SYS) SFR_WR = 0;
    @(negedge CLK_SYS);
  endtask
  task sfr_read(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    SFR_ADDR = a;
    SFR_RD = 1;
    @(negedge CLK_SYS) SFR_RD = 0;
    @(negedge CLK_SYS);
  endtask
  task pulse_done;
    INSTR_DONE = 1;
    @(negedge CLK_SYS) INSTR_DONE = 0;
  endtask
  task wait_mode(input logic [4:0] e);
    n = 0;
    while (MODE !== e && n < 40) begin
      @(negedge CLK_SYS);
      n++;
    end
    `CHK("mode", e, MODE)
  endtask
  task enter(input logic [7:0] a, input logic [7:0] d, input logic [4:0] m);
    sfr_write(a, d);
    pulse_done();
    wait_mode(m);
  endtask
  task flash_read(input int ex, input logic inv);
    FLASH_READ_REQ = 1;
    @(negedge CLK_SYS) FLASH_READ_REQ = 0;
    `CHK("third fetch flag", inv, OPCODE3_INVALID)
    n = 1;
    while (FLASH_READ_DONE !== 1'b1 && n < 40) begin
      @(negedge CLK_SYS);
      n++;
    end
    `CHK("read cycles", ex, n)
    @(negedge CLK_SYS);
  endtask
  task wrap_up;
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(negedge CLK_SYS);
    RSTN = 1;
    sfr_read(`ADDR_POWER_CONTROL, `RST_POWER_CONTROL);
    sfr_read(8'h10, 8'h00);
    `CHK("hit", 1'b0, SFR_HIT)
    sfr_write(`ADDR_FLASH_READ_SCALE, 8'hff);
    sfr_read(`ADDR_FLASH_READ_SCALE, 8'h40);
    `CHK("hit", 1'b1, SFR_HIT)
    for (int i = 0; i < 8; i++) begin
      sc = {1'b0, 1'($random(seed)), 6'h00};
      sfr_write(`ADDR_DUMMY_WRITE_SINK, 8'($random(seed)));
      sfr_write(`ADDR_FLASH_READ_SCALE, sc);
      sfr_read(`ADDR_DUMMY_WRITE_SINK, 8'h00);
      sfr_read(`ADDR_FLASH_READ_SCALE, sc);
    end
    sfr_write(`ADDR_FLASH_READ_SCALE, 8'h40);
    flash_read(2, 1'b0);
    sfr_write(`ADDR_FLASH_READ_SCALE, 8'h00);
    sfr_write(`ADDR_DUMMY_WRITE_SINK, 8'h5a);
    flash_read(OS + 1, 1'b0);
    flash_read(OS + 1, 1'b0);
    flash_read(OS + 1, 1'b1);
    sfr_write(`ADDR_POWER_CONTROL, 8'h01);
    `CHK("mode before retire", 5'h01, MODE)
    pulse_done();
    wait_mode(5'h02);
    sfr_read(`ADDR_FLASH_READ_SCALE, 8'h00);
    INT_PENDING = 1;
    n = 0;
    while (INT_SERVICE !== 1'b1 && n < 20) begin
      @(negedge CLK_SYS);
      n++;
    end
    `CHK("int service", 1'b1, INT_SERVICE)
    `CHK("resume next", 1'b1, RESUME_NEXT)
    `CHK("halt", 1'b0, CPU_HALT)
    INT_PENDING = 0;
    repeat (4) @(negedge CLK_SYS);
    sfr_read(`ADDR_POWER_CONTROL, 8'h00);
    enter(`ADDR_POWER_CONTROL, 8'h01, 5'h02);
    WDT_RESET = 1;
    repeat (8) @(negedge CLK_SYS);
    `CHK("mode", 5'h02, MODE)
    WDT_ENABLED = 1;
    wait_mode(5'h01);
    `CHK("resume vector", `RESET_VECTOR, RESUME_PC_SEL)
    WDT_RESET = 0;
    WDT_ENABLED = 0;
    repeat (4) @(negedge CLK_SYS);
    enter(`ADDR_POWER_CONTROL, 8'h02, 5'h04);
    INT_PENDING = 1;
    repeat (8) @(negedge CLK_SYS);
    `CHK("mode", 5'h04, MODE)
    `CHK("precision osc", 1'b0, PRECISION_OSC_EN)
    INT_PENDING = 0;
    RSTN = 0;
    @(negedge CLK_SYS) RSTN = 1;
    `CHK("mode", 5'h01, MODE)
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 4; s++) begin
        enter(`ADDR_PMU_CONFIG, m ? 8'h80 : 8'h40, m ? 5'h10 : 5'h08);
        `CHK("clock gate", 1'b1, SYSCLK_GATE)
        `CHK("core supply", m ? 1'b0 : 1'b1, CORE_SUPPLY_EN)
        wake[s] = 1;
        wait_mode(5'h01);
        `CHK("resume next", 1'b1, RESUME_NEXT)
        wake = 4'h0;
        repeat (4) @(negedge CLK_SYS);
      end
    end
    // Single cell: comparator may not wake the part from sleep
    TWO_CELL = 0;
    enter(`ADDR_PMU_CONFIG, 8'h80, 5'h10);
    wake = 4'h4;
    repeat (8) @(negedge CLK_SYS);
    `CHK("mode", 5'h10, MODE)
    wake = 4'h1;
    wait_mode(5'h01);
    wrap_up();
  end
endmodule // testbench
